/* File: core/hbp_seq.v */
/*
 half-bridge pwm sequencer top: primary drives, rectifier controls, duty limit, start-up and thermal gating.
 assumes all status inputs from the analog side are synchronous to pclk;
 the oscillator period counts 10 ns cycles.
*/
`include "hbp_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module hbp_seq #(
   parameter CNT_W = 16,
   parameter DLY_W = 8
) (
   // clock, reset, enable
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   // apb
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // sync and analog status comparators
   input wire freq_set_pin,
   input wire line_above_shutdown,
   input wire line_above_standby,
   input wire vcc_above_ref_on,
   input wire vcc_above_startup_off,
   input wire vcc_in_reg,
   input wire ref_in_reg,
   input wire over_temp,
   input wire soft_start_low,
   input wire duty_demand_valid,
   // drive outputs
   output reg high_side_drive,
   output reg low_side_drive,
   output reg rect_a_ctrl,
   output reg rect_b_ctrl,
   // bias and soft-start controls
   output reg vcc_reg_en,
   output reg ref_en,
   output reg startup_reg_en,
   output reg soft_start_discharge
);
   // sequencer states
   localparam ST_OFF = 4'b0001;
   localparam ST_SOFT = 4'b0010;
   localparam ST_RUN = 4'b0100;
   localparam ST_HOT = 4'b1000;
   // fixed deadtime and minimum deadtime at the widths they are used at
   localparam [CNT_W-1:0] TD_CYC = `HBP_TD_CYC;
   localparam [DLY_W-1:0] MIN_DLY = `HBP_MIN_DLY_CYC;

   wire [2:0] ctrl;
   wire [15:0] period;
   wire [15:0] demand;
   wire [7:0] lead_reg;
   wire [7:0] trail_reg;
   wire [15:0] cnt;
   wire cyc_end;
   wire synced;
   wire [6:0] status;
   reg [3:0] state_q;
   reg [3:0] state_d;
   reg phase_q;
   reg [CNT_W-1:0] width;
   reg [CNT_W-1:0] max_w;
   reg [DLY_W-1:0] lead;
   reg [DLY_W-1:0] trail;
   reg pulse_on;
   reg rect_a_d;
   reg rect_b_d;
   wire enabled;

   hbp_apb u_apb (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .ctrl_q(ctrl),
      .period_q(period),
      .demand_q(demand),
      .lead_q(lead_reg),
      .trail_q(trail_reg),
      .status(status)
   );

   hbp_osc u_osc (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .period(period),
      .sync_en(ctrl[`HBP_CTRL_SYNC_EN]),
      .freq_set_pin(freq_set_pin),
      .cnt_q(cnt),
      .cyc_end(cyc_end),
      .synced_q(synced)
   );

   assign status = {synced, (state_q == ST_HOT), startup_reg_en, ref_en, vcc_reg_en,
                    (state_q == ST_RUN), phase_q};

   // outputs enable only with both regulators good and line above standby
   assign enabled = vcc_in_reg & ref_in_reg & line_above_standby & ~over_temp;

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_OFF: begin
            if (enabled) begin
               state_d = ST_SOFT;
            end
         end
         ST_SOFT: begin
            if (over_temp) begin
               state_d = ST_HOT;
            end else if (!enabled) begin
               state_d = ST_OFF;
            end else if (!soft_start_low) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (over_temp) begin
               state_d = ST_HOT;
            end else if (!enabled || soft_start_low) begin
               state_d = ST_SOFT;
            end
         end
         ST_HOT: begin
            if (!over_temp) begin
               state_d = ST_OFF;
            end
         end
         default: state_d = ST_OFF;
      endcase
   end

   // deadtime selection: unconfigured pin uses propagation delay only
   always @* begin
      if (ctrl[`HBP_CTRL_DLY_SET]) begin
         lead = lead_reg;
         trail = trail_reg;
      end else begin
         lead = MIN_DLY;
         trail = MIN_DLY;
      end
   end

   // pulse window inside each oscillator cycle: lead, pulse, then trail
   always @* begin
      // half of one output period equals one oscillator period
      if (period > TD_CYC + {8'h0, lead})
         max_w = period - TD_CYC - {8'h0, lead};
      else
         max_w = {CNT_W{1'b0}};
      if (!ctrl[`HBP_CTRL_DEMAND_EN] || !duty_demand_valid || demand > max_w)
         width = max_w;
      else
         width = demand;
      pulse_on = (state_q == ST_RUN) && !soft_start_low && (cnt >= {8'h0, lead}) &&
                 (cnt < {8'h0, lead} + width) && !cyc_end;
   end

   // rectifier pattern around the active phase
   always @* begin
      rect_a_d = 1'b0;
      rect_b_d = 1'b0;
      if (state_q == ST_RUN) begin
         if (cnt < {8'h0, lead} + width + {8'h0, trail} && cnt >= {8'h0, lead}) begin
            // active pulse plus trail keeps the opposite rectifier only
            rect_a_d = phase_q;
            rect_b_d = ~phase_q;
         end else if (cnt < {8'h0, lead}) begin
            // during lead the rectifier that would short the coming pulse is already off
            rect_a_d = phase_q;
            rect_b_d = ~phase_q;
         end else begin
            rect_a_d = 1'b1;
            rect_b_d = 1'b1;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_OFF;
         phase_q <= 1'b0;
         high_side_drive <= 1'b0;
         low_side_drive <= 1'b0;
         rect_a_ctrl <= 1'b0;
         rect_b_ctrl <= 1'b0;
         vcc_reg_en <= 1'b0;
         ref_en <= 1'b0;
         startup_reg_en <= 1'b0;
         soft_start_discharge <= 1'b1;
      end else if (clk_en) begin
         state_q <= state_d;
         if (cyc_end) begin
            phase_q <= ~phase_q;
         end
         // phase 0 belongs to the high side; one drive per cycle only
         high_side_drive <= pulse_on & ~phase_q;
         low_side_drive <= pulse_on & phase_q;
         rect_a_ctrl <= rect_a_d;
         rect_b_ctrl <= rect_b_d;
         vcc_reg_en <= line_above_shutdown & ~over_temp;
         ref_en <= line_above_shutdown & vcc_above_ref_on & ~over_temp;
         startup_reg_en <= line_above_shutdown & ~vcc_above_startup_off & ~over_temp;
         soft_start_discharge <= (state_d != ST_RUN) && (state_d != ST_SOFT || soft_start_low ||
                                 state_q != ST_SOFT);
      end
   end
endmodule // hbp_seq
`default_nettype wire

/* File: core/hbp_regs.vh */
/*
 holds register offsets, field positions, reset values and timing counts of the half-bridge sequencer.
 assumes a 100 MHz pclk and an APB slave with 32-bit data.
*/
`ifndef HBP_REGS_VH
`define HBP_REGS_VH
// register byte offsets
`define HBP_CTRL_OFF 12'h000
`define HBP_PERIOD_OFF 12'h004
`define HBP_DEMAND_OFF 12'h008
`define HBP_LEAD_OFF 12'h00c
`define HBP_TRAIL_OFF 12'h010
`define HBP_STATUS_OFF 12'h014
// control fields
`define HBP_CTRL_DEMAND_EN 0
`define HBP_CTRL_DLY_SET 1
`define HBP_CTRL_SYNC_EN 2
// status fields
`define HBP_ST_PHASE 0
`define HBP_ST_RUN 1
`define HBP_ST_VCC_EN 2
`define HBP_ST_REF_EN 3
`define HBP_ST_STARTUP 4
`define HBP_ST_THERMAL 5
`define HBP_ST_SYNCED 6
// reset values, in 10 ns counts
`define HBP_CTRL_RST 32'h0000_0004
`define HBP_PERIOD_RST 16'h00fa
`define HBP_DEMAND_RST 16'h0000
`define HBP_LEAD_RST 8'h01
`define HBP_TRAIL_RST 8'h02
// timing in ns and derived cycle counts (clock period 10 ns)
`define HBP_CLK_NS 10
`define HBP_TD_NS 70
`define HBP_TD_CYC ((`HBP_TD_NS + `HBP_CLK_NS - 1) / `HBP_CLK_NS)
`define HBP_MIN_DLY_NS 5
`define HBP_MIN_DLY_CYC ((`HBP_MIN_DLY_NS + `HBP_CLK_NS - 1) / `HBP_CLK_NS)
`endif

/* File: core/hbp_apb.v */
/*
 APB slave with the sequencer's control, timing and status registers.
 assumes synchronous APB signals on pclk; answers with zero wait states.
*/
`include "hbp_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module hbp_apb (
   // clock, reset, enable
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   // apb
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // register contents
   output reg [2:0] ctrl_q,
   output reg [15:0] period_q,
   output reg [15:0] demand_q,
   output reg [7:0] lead_q,
   output reg [7:0] trail_q,
   input wire [6:0] status
);
   // reset word kept at full width, only the implemented control bits are loaded
   localparam [31:0] CTRL_RST = `HBP_CTRL_RST;
   wire wr;
   wire hit;
   assign pready = 1'b1;
   assign hit = (paddr == `HBP_CTRL_OFF) || (paddr == `HBP_PERIOD_OFF) || (paddr == `HBP_DEMAND_OFF) ||
                (paddr == `HBP_LEAD_OFF) || (paddr == `HBP_TRAIL_OFF) || (paddr == `HBP_STATUS_OFF);
   // unmapped addresses answer with an error and read zero
   assign pslverr = psel & penable & ~hit;
   assign wr = psel & penable & pwrite & clk_en;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RST[2:0];
         period_q <= `HBP_PERIOD_RST;
         demand_q <= `HBP_DEMAND_RST;
         lead_q <= `HBP_LEAD_RST;
         trail_q <= `HBP_TRAIL_RST;
      end else if (wr) begin
         case (paddr)
            `HBP_CTRL_OFF: ctrl_q <= pwdata[2:0];
            `HBP_PERIOD_OFF: period_q <= pwdata[15:0];
            `HBP_DEMAND_OFF: demand_q <= pwdata[15:0];
            `HBP_LEAD_OFF: lead_q <= pwdata[7:0];
            `HBP_TRAIL_OFF: trail_q <= pwdata[7:0];
            default: ;
         endcase
      end
   end
   always @* begin
      case (paddr)
         `HBP_CTRL_OFF: prdata = {29'h0, ctrl_q};
         `HBP_PERIOD_OFF: prdata = {16'h0, period_q};
         `HBP_DEMAND_OFF: prdata = {16'h0, demand_q};
         `HBP_LEAD_OFF: prdata = {24'h0, lead_q};
         `HBP_TRAIL_OFF: prdata = {24'h0, trail_q};
         `HBP_STATUS_OFF: prdata = {25'h0, status};
         default: prdata = 32'h0;
      endcase
   end
endmodule // hbp_apb
`default_nettype wire

/* File: core/hbp_osc.v */
/*
 oscillator period counter with sync capture.
 assumes freq_set_pin is a synchronous sync pulse input on pclk.
*/
`include "hbp_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module hbp_osc (
   // clock, reset, enable
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   // configuration
   input wire [15:0] period,
   input wire sync_en,
   input wire freq_set_pin,
   // timing
   output reg [15:0] cnt_q,
   output wire cyc_end,
   output reg synced_q
);
   reg sync_prev_q;
   reg [15:0] gap_q;
   wire sync_rise;
   wire sync_ok;
   wire natural_end;
   assign sync_rise = freq_set_pin & ~sync_prev_q;
   assign natural_end = (cnt_q >= period - 16'h0001);
   // a sync edge counts only if it follows the last one sooner than our own period;
   // so slower sync never cuts a cycle, and the first edge after reset only arms lock
   assign sync_ok = sync_en & sync_rise & (gap_q < period - 16'h0001);
   assign cyc_end = natural_end | sync_ok;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 16'h0;
         sync_prev_q <= 1'b0;
         synced_q <= 1'b0;
         gap_q <= 16'hffff;
      end else if (clk_en) begin
         sync_prev_q <= freq_set_pin;
         if (sync_rise) begin
            gap_q <= 16'h0000;
         end else if (gap_q != 16'hffff) begin
            gap_q <= gap_q + 16'h0001;
         end
         if (cyc_end) begin
            cnt_q <= 16'h0;
            synced_q <= ~natural_end;
         end else begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end
endmodule // hbp_osc
`default_nettype wire

/* File: tb/hbp_seq_sva.sv */
/*
 assertions on the sequencer top ports.
 assumes one pclk domain and clk_en held high by the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module hbp_seq_sva (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // status inputs
   input wire logic line_above_shutdown,
   input wire logic line_above_standby,
   input wire logic vcc_above_ref_on,
   input wire logic vcc_above_startup_off,
   input wire logic over_temp,
   input wire logic soft_start_low,
   // outputs
   input wire logic high_side_drive,
   input wire logic low_side_drive,
   input wire logic rect_a_ctrl,
   input wire logic rect_b_ctrl,
   input wire logic vcc_reg_en,
   input wire logic ref_en,
   input wire logic startup_reg_en,
   input wire logic soft_start_discharge
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_NO_OVERLAP: assert property (!(high_side_drive && low_side_drive))
      else $error("both primary drives on");
   AST_HIGH_RECT: assert property (high_side_drive |-> rect_b_ctrl && !rect_a_ctrl)
      else $error("rectifiers wrong in high pulse");
   AST_LOW_RECT: assert property (low_side_drive |-> rect_a_ctrl && !rect_b_ctrl)
      else $error("rectifiers wrong in low pulse");
   AST_LOW_LEAD: assert property ($rose(low_side_drive) |-> !$past(rect_b_ctrl))
      else $error("rect_b still on at low pulse start");
   AST_THERMAL: assert property (over_temp [*3] |-> soft_start_discharge && !(high_side_drive || low_side_drive ||
      rect_a_ctrl || rect_b_ctrl || vcc_reg_en || ref_en)) else $error("standby not entered");
   AST_SOFT_STOP: assert property (soft_start_low [*3] |-> !(high_side_drive || low_side_drive))
      else $error("pulses with soft-start low");
   AST_VCC_OFF: assert property ((!line_above_shutdown) [*2] |-> !vcc_reg_en)
      else $error("vcc regulator on below shutdown level");
   AST_REF_OFF: assert property ((!vcc_above_ref_on) [*2] |-> !ref_en)
      else $error("reference on before vcc level");
   AST_STARTUP_OFF: assert property (vcc_above_startup_off [*2] |-> !startup_reg_en)
      else $error("start-up regulator still on");
   AST_LINE_GATE: assert property ((!line_above_standby) [*3] |-> !(high_side_drive || low_side_drive))
      else $error("drives on below standby level");
   cover property ($rose(high_side_drive));
   cover property ($rose(low_side_drive));
   cover property (over_temp && soft_start_discharge);
endmodule // hbp_seq_sva
bind hbp_seq hbp_seq_sva u_sva (.pclk, .presetn, .line_above_shutdown, .line_above_standby, .vcc_above_ref_on,
   .vcc_above_startup_off, .over_temp, .soft_start_low, .high_side_drive, .low_side_drive, .rect_a_ctrl,
   .rect_b_ctrl, .vcc_reg_en, .ref_en, .startup_reg_en, .soft_start_discharge);
`default_nettype wire

/* File: tb/hbp_sync_src.sv */
/*
 external sync source standing in for the party that locks the oscillator.
 assumes per is changed only between measurements; per of zero keeps the line low.
*/
`timescale 1ns/1ns
`default_nettype none
module hbp_sync_src (
   // clock and setting
   input wire logic clk,
   input wire logic [7:0] per,
   // sync pulse
   output logic pulse
);
   logic [7:0] cnt_q;
   initial begin
      cnt_q = 8'h00;
      pulse = 1'b0;
   end
   // two cycles high is 20 ns, wide enough and far below 60 percent of any period used
   always @(posedge clk) begin
      cnt_q <= (cnt_q + 8'h01 >= per) ? 8'h00 : cnt_q + 8'h01;
      pulse <= (per != 8'h00) && (cnt_q < 8'h02);
   end
endmodule // hbp_sync_src
`default_nettype wire

/* File: tb/hbp_seq_test.sv */
/*
 self-checking bench for the sequencer: register table, start-up, duty limit, sync and shutdown.
 assumes hbp_regs.vh on the include path and the checker bound to the top.
*/
`include "hbp_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module hbp_seq_test;
   logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   logic err;
   logic lsd = 0, lst = 0, vro = 0, vso = 0, vir = 0, rir = 0, ot = 0, ssl = 0, ddv = 0;
   logic [7:0] sync_per = 8'h00;
   wire [31:0] prdata;
   wire pready, pslverr, fsp, hs, ls, ra, rb, vce, rfe, sre, ssd;
   integer n_fail = 0, n_compared = 0, i, per, wid, both;
   logic [11:0] r_addr [6] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h018};
   logic [31:0] r_val [6] = '{32'h4, 32'hfa, 32'h0, 32'h1, 32'h2, 32'h0};
   logic r_err [6] = '{0, 0, 0, 0, 0, 1};
   always #5 pclk = ~pclk;
   hbp_seq DUT (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .freq_set_pin(fsp), .line_above_shutdown(lsd), .line_above_standby(lst), .vcc_above_ref_on(vro),
      .vcc_above_startup_off(vso), .vcc_in_reg(vir), .ref_in_reg(rir), .over_temp(ot), .soft_start_low(ssl),
      .duty_demand_valid(ddv), .high_side_drive(hs), .low_side_drive(ls), .rect_a_ctrl(ra), .rect_b_ctrl(rb),
      .vcc_reg_en(vce), .ref_en(rfe), .startup_reg_en(sre), .soft_start_discharge(ssd));
   hbp_sync_src u_sync (.clk(pclk), .per(sync_per), .pulse(fsp));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // one idle cycle after each transfer so back-to-back calls never drive psel twice in one step
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   // period, pulse width of the high drive, and count of shared-rectifier cycles; second pass is settled
   task measure;
      integer k, p;
      for (p = 0; p < 2; p++) begin
         per = 0;
         wid = 0;
         both = 0;
         k = 0;
         while (!(hs === 1'b0) && k < 500) begin k++; @(posedge pclk); end
         while (hs !== 1'b1 && k < 500) begin k++; @(posedge pclk); end
         while (hs === 1'b1 && k < 500) begin k++; wid++; per++; @(posedge pclk); end
         while (hs !== 1'b1 && k < 500) begin
            k++;
            per++;
            if (ls === 1'b0 && ra === 1'b1 && rb === 1'b1) both++;
            @(posedge pclk);
         end
      end
   endtask
   task conclude;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      conclude;
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      for (i = 0; i < 6; i++) begin
         apb(0, r_addr[i], 0);
         chk(rd, r_val[i]);
         chk(err, r_err[i]);
      end
      apb(1, `HBP_PERIOD_OFF, 32'd40);
      apb(0, `HBP_PERIOD_OFF, 0);
      chk(rd, 32'd40);
      // still inside the first oscillator cycle, so the phase flop holds its reset value
      apb(0, `HBP_STATUS_OFF, 0);
      chk(rd[`HBP_ST_PHASE], 0);
      chk(rd[`HBP_ST_RUN], 0);
      lsd <= 1;
      repeat (3) @(posedge pclk);
      chk(vce, 1);
      vro <= 1;
      vso <= 1;
      vir <= 1;
      rir <= 1;
      repeat (3) @(posedge pclk);
      chk({rfe, sre, hs}, 3'b100);
      lst <= 1;
      apb(1, `HBP_LEAD_OFF, 3);
      measure;
      chk(per, 80);
      chk(wid, 32);
      chk(both > 0, 1);
      apb(1, `HBP_CTRL_OFF, 32'h6);
      measure;
      chk(wid, 30);
      apb(1, `HBP_DEMAND_OFF, 10);
      apb(1, `HBP_CTRL_OFF, 32'h7);
      ddv <= 1;
      measure;
      chk(wid, 10);
      ddv <= 0;
      measure;
      chk(wid, 30);
      sync_per <= 8'd36;
      measure;
      chk(per, 72);
      sync_per <= 8'd50;
      measure;
      chk(per, 80);
      sync_per <= 8'd0;
      ssl <= 1;
      repeat (4) @(posedge pclk);
      chk({hs, ls}, 0);
      ssl <= 0;
      measure;
      chk(per, 80);
      ot <= 1;
      repeat (4) @(posedge pclk);
      chk({vce, ssd, ra, rb}, 4'b0100);
      ot <= 0;
      measure;
      chk(wid, 30);
      // reset in mid-run: everything off and soft-start discharged at once
      presetn <= 0;
      @(posedge pclk);
      chk({hs, ls, ra, rb, vce, ssd}, 6'b000001);
      presetn <= 1;
      @(posedge pclk);
      @(posedge pclk);
      chk({hs, ls}, 0);
      conclude;
   end
endmodule // hbp_seq_test
`default_nettype wire
